// ===== logic/ion_pump_hv_supervisor_regs.vh
// constants of the ion pump high-voltage supervisor and its serial command port
// assumes a 200 MHz system clock
`ifndef ION_PUMP_HV_SUPERVISOR_REGS_VH
`define ION_PUMP_HV_SUPERVISOR_REGS_VH
`define CLK_HZ 32'h0BEBC200
`define SEC_TIME_S 32'h00000001
`define SEC_CYCLES_DEF 28'hBEBC200
`define DIV_FAST_DEF 17'h05161
`define DIV_MID_DEF 17'h0A2C2
`define DIV_SLOW_DEF 17'h14585
`define SOFT_ON_S 2'h1
`define SOFT_OFF_S 2'h2
`define RUN_LOW_S 2'h2
`define SEC_PER_MIN 14'h003C
`define TMO_MIN_LO 8'h01
`define BAUD_FAST 32'h00002580
`define BAUD_MID 32'h000012C0
`define BAUD_SLOW 32'h00000960
`define BAUD_SEL_RESET 2'h0
`define ERR_INTERLOCK 4'h0
`define ERR_EARTH 4'h1
`define ERR_TIMEOUT 4'h2
`define ERR_RUN 4'h3
`define ERR_HV_OUTPUT 4'h4
`define ERR_INPUT_V 4'h5
`define ERR_TEMP 4'h6
`define ERR_SERIAL 4'h7
`define ERR_NVM 4'h8
`define METER_RESET 3'h1
`define FIFO_DEPTH 32
`endif

// ===== logic/ion_pump_hv_supervisor_serial_cmd.v
// ion pump high-voltage supervisor with serial command interpreter and reply fifo
// assumes one system clock; single-bit pin inputs are asynchronous and synchronised here
`timescale 1ns/10ps
`default_nettype none
`include "ion_pump_hv_supervisor_regs.vh"

module reply_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `FIFO_DEPTH,
   parameter AW = 5
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = (count != DEPTH);
   assign out_valid_o = (count != 0);
   assign out_data_o = mem[rd_ptr];
   always @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // reply_fifo

module ion_pump_hv_supervisor_serial_cmd #(
   parameter [27:0] SEC_CYCLES = `SEC_CYCLES_DEF,
   parameter [16:0] DIV_FAST = `DIV_FAST_DEF,
   parameter [16:0] DIV_MID = `DIV_MID_DEF,
   parameter [16:0] DIV_SLOW = `DIV_SLOW_DEF,
   parameter FIFO_DEPTH = `FIFO_DEPTH
) (
   input wire clk_sys_i,
   input wire rst_i,
   input wire uart_rx_i,
   output reg uart_tx_o,
   input wire [1:0] baud_sel_i,
   input wire remote_mode_i,
   input wire hv_request_i,
   input wire power_key_i,
   input wire interlock_closed_i,
   input wire earth_fault_i,
   input wire current_high_i,
   input wire voltage_low_i,
   input wire no_output_i,
   input wire input_voltage_mismatch_i,
   input wire over_temp_i,
   input wire nvm_checksum_bad_i,
   input wire pressure_below_p1_i,
   input wire pressure_below_p2_i,
   input wire below_measure_limit_i,
   input wire [7:0] startup_timeout_min_i,
   input wire [15:0] meter_value_i,
   output reg hv_output_o,
   output reg hv_lamp_o,
   output reg run_o,
   output reg error_o,
   output reg [3:0] error_code_o,
   output reg [2:0] meter_range_o,
   output reg meter_mode_o
);
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ON = 2'h1;
   localparam [1:0] ST_OFF = 2'h2;
   localparam [1:0] ST_RUN = 2'h3;
   localparam [1:0] RX_IDLE = 2'h0;
   localparam [1:0] RX_START = 2'h1;
   localparam [1:0] RX_DATA = 2'h2;
   localparam [1:0] RX_STOP = 2'h3;
   localparam [7:0] CH_CR = 8'h0D;
   localparam [7:0] CH_LF = 8'h0A;
   localparam [7:0] CH_A = 8'h41;
   localparam [7:0] CH_B = 8'h42;
   localparam [7:0] CH_C = 8'h43;
   localparam [7:0] CH_D = 8'h44;
   localparam [7:0] CH_H = 8'h48;
   localparam [7:0] CH_M = 8'h4D;
   localparam NIN = 15;
   // serial line idles high and the loop idles closed: no false fault after reset
   localparam [NIN-1:0] SYNC_IDLE = 15'h4400;

   function [7:0] hex_ch;
      input [3:0] n;
      begin
         if (n < 4'hA) begin
            hex_ch = {4'h3, n};
         end else begin
            hex_ch = {4'h0, n} + 8'h37;
         end
      end
   endfunction

   // two-flop synchronisers for every single-bit pin input
   wire [NIN-1:0] async_in = {uart_rx_i, remote_mode_i, hv_request_i, power_key_i, interlock_closed_i,
      earth_fault_i, current_high_i, voltage_low_i, no_output_i, input_voltage_mismatch_i,
      over_temp_i, nvm_checksum_bad_i, pressure_below_p1_i, pressure_below_p2_i, below_measure_limit_i};
   reg [NIN-1:0] sync_a;
   reg [NIN-1:0] sync_b;
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
         always @(posedge clk_sys_i) begin
            if (rst_i) begin
               sync_a[gi] <= SYNC_IDLE[gi];
               sync_b[gi] <= SYNC_IDLE[gi];
            end else begin
               sync_a[gi] <= async_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate
   wire rx = sync_b[14];
   wire remote = sync_b[13];
   wire hv_req = sync_b[12];
   wire key = sync_b[11];
   wire ilk_ok = sync_b[10];
   wire earth = sync_b[9];
   wire cur_high = sync_b[8];
   wire v_low = sync_b[7];
   wire no_out = sync_b[6];
   wire vin_bad = sync_b[5];
   wire hot = sync_b[4];
   wire nvm_bad = sync_b[3];
   wire below_p1 = sync_b[2];
   wire below_p2 = sync_b[1];
   wire below_lim = sync_b[0];
   reg hv_req_d;
   reg key_d;
   reg rx_d;
   wire req_fall = hv_req_d && !hv_req;
   wire key_rise = key && !key_d;

   reg [16:0] bit_div;
   always @* begin
      case (baud_sel_i)
         2'h1: bit_div = DIV_MID;
         2'h2: bit_div = DIV_SLOW;
         default: bit_div = DIV_FAST;
      endcase
   end

   // receiver: 8 data bits lsb first, one stop bit, no parity
   reg [1:0] rx_st;
   reg [16:0] rx_cnt;
   reg [2:0] rx_bit;
   reg [7:0] rx_sh;
   reg rx_done;
   reg rx_ferr;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         rx_st <= RX_IDLE;
         rx_cnt <= 17'h00000;
         rx_bit <= 3'h0;
         rx_sh <= 8'h00;
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
      end else begin
         rx_done <= 1'b0;
         rx_ferr <= 1'b0;
         if (rx_st == RX_IDLE) begin
            if (rx_d && !rx) begin
               rx_st <= RX_START;
               rx_cnt <= {1'b0, bit_div[16:1]};
            end
         end else if (rx_cnt != 17'h00000) begin
            rx_cnt <= rx_cnt - 17'h00001;
         end else begin
            rx_cnt <= bit_div - 17'h00001;
            case (rx_st)
               RX_START: begin
                  rx_st <= rx ? RX_IDLE : RX_DATA;
                  rx_bit <= 3'h0;
               end
               RX_DATA: begin
                  rx_sh <= {rx, rx_sh[7:1]};
                  rx_bit <= rx_bit + 3'h1;
                  if (rx_bit == 3'h7) begin
                     rx_st <= RX_STOP;
                  end
               end
               default: begin
                  rx_st <= RX_IDLE;
                  rx_done <= rx;
                  rx_ferr <= !rx;
               end
            endcase
         end
      end
   end

   // command assembly: letter, first argument char, ended by CR
   reg [7:0] cmd_ch;
   reg [7:0] arg_ch;
   reg arg_seen;
   reg exec;
   reg [7:0] ex_ch;
   reg [7:0] ex_arg;
   reg ex_noarg;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         cmd_ch <= 8'h00;
         arg_ch <= 8'h00;
         arg_seen <= 1'b0;
         exec <= 1'b0;
         ex_ch <= 8'h00;
         ex_arg <= 8'h00;
         ex_noarg <= 1'b1;
      end else begin
         exec <= 1'b0;
         if (rx_done) begin
            if (rx_sh == CH_CR) begin
               exec <= (cmd_ch != 8'h00);
               ex_ch <= cmd_ch;
               ex_arg <= arg_ch;
               ex_noarg <= !arg_seen;
               cmd_ch <= 8'h00;
               arg_seen <= 1'b0;
            end else if (cmd_ch == 8'h00) begin
               cmd_ch <= rx_sh;
            end else if (!arg_seen) begin
               arg_ch <= rx_sh;
               arg_seen <= 1'b1;
            end
         end
      end
   end
   reg resp_busy;
   wire go = exec && !resp_busy;
   wire known = (ex_ch == CH_A) || (ex_ch == CH_B) || (ex_ch == CH_C) || (ex_ch == CH_D) ||
      (ex_ch == CH_H) || (ex_ch == CH_M);
   wire cmd_clear = go && (ex_ch == CH_C);
   wire cmd_h0 = go && (ex_ch == CH_H) && !ex_noarg && (ex_arg == 8'h30);
   wire cmd_h1 = go && (ex_ch == CH_H) && !ex_noarg && (ex_arg == 8'h31);
   wire cmd_m = go && (ex_ch == CH_M);

   // error handling: level errors follow their cause, stop errors latch
   reg lat_valid;
   reg [3:0] lat_code;
   reg [1:0] st;
   reg [1:0] next_st;
   reg [1:0] ph;
   reg [1:0] low_sec;
   reg [13:0] tmo_sec;
   reg [27:0] pre;
   reg hv_cmd_on;
   wire sec_tick = (pre == SEC_CYCLES - 28'h0000001);
   wire lvl_err = !ilk_ok || earth || vin_bad || hot || nvm_bad;
   wire err_any = lvl_err || lat_valid;
   wire want = remote ? hv_req : hv_cmd_on;
   wire [7:0] tmo_min = (startup_timeout_min_i < `TMO_MIN_LO) ? `TMO_MIN_LO : startup_timeout_min_i;
   wire [13:0] tmo_lim = {6'h00, tmo_min} * `SEC_PER_MIN;
   wire cycling = (st == ST_ON) || (st == ST_OFF);
   wire set_tmo = cycling && cur_high && sec_tick && (tmo_sec + 14'h0001 >= tmo_lim);
   wire set_run = (st == ST_RUN) && v_low && sec_tick && (low_sec + 2'h1 >= `RUN_LOW_S);
   wire set_hv = ((st == ST_ON) || (st == ST_RUN)) && no_out;
   wire set_ser = rx_ferr || (go && !known);
   wire clr_23 = (remote && req_fall) || (!remote && key_rise);
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         lat_valid <= 1'b0;
         lat_code <= `ERR_TIMEOUT;
      end else if (!lat_valid && (set_tmo || set_run || set_hv || set_ser)) begin
         lat_valid <= 1'b1;
         if (set_tmo) begin
            lat_code <= `ERR_TIMEOUT;
         end else if (set_run) begin
            lat_code <= `ERR_RUN;
         end else if (set_hv) begin
            lat_code <= `ERR_HV_OUTPUT;
         end else begin
            lat_code <= `ERR_SERIAL;
         end
      end else if (lat_valid && cmd_clear) begin
         lat_valid <= 1'b0;
      end else if (lat_valid && clr_23 && ((lat_code == `ERR_TIMEOUT) || (lat_code == `ERR_RUN))) begin
         lat_valid <= 1'b0;
      end
   end

   // start-up sequencing
   always @* begin
      next_st = st;
      case (st)
         ST_IDLE: begin
            if (want && !err_any) begin
               next_st = ST_ON;
            end
         end
         ST_ON: begin
            if (err_any || !want) begin
               next_st = ST_IDLE;
            end else if (!cur_high) begin
               next_st = ST_RUN;
            end else if (sec_tick && (ph + 2'h1 == `SOFT_ON_S)) begin
               next_st = ST_OFF;
            end
         end
         ST_OFF: begin
            if (err_any || !want) begin
               next_st = ST_IDLE;
            end else if (sec_tick && (ph + 2'h1 == `SOFT_OFF_S)) begin
               next_st = ST_ON;
            end
         end
         ST_RUN: begin
            if (err_any || !want) begin
               next_st = ST_IDLE;
            end
         end
         default: next_st = ST_IDLE;
      endcase
   end
   // the second prescaler restarts on each phase and, in run, while voltage is good
   wire pre_clr = (st != next_st) || ((st == ST_RUN) && !v_low);
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         st <= ST_IDLE;
         pre <= 28'h0000000;
         ph <= 2'h0;
         low_sec <= 2'h0;
         tmo_sec <= 14'h0000;
         hv_cmd_on <= 1'b0;
         hv_req_d <= 1'b0;
         key_d <= 1'b0;
         rx_d <= 1'b0;
      end else begin
         hv_req_d <= hv_req;
         key_d <= key;
         rx_d <= rx;
         st <= next_st;
         pre <= (pre_clr || sec_tick) ? 28'h0000000 : pre + 28'h0000001;
         ph <= (st != next_st) ? 2'h0 : (sec_tick ? ph + 2'h1 : ph);
         if (st != ST_RUN || !v_low) begin
            low_sec <= 2'h0;
         end else if (sec_tick && low_sec != 2'h3) begin
            low_sec <= low_sec + 2'h1;
         end
         if (st == ST_IDLE) begin
            tmo_sec <= 14'h0000;
         end else if (cycling && sec_tick) begin
            tmo_sec <= tmo_sec + 14'h0001;
         end
         if (cmd_h1) begin
            hv_cmd_on <= 1'b1;
         end else if (cmd_h0 || cmd_clear || err_any) begin
            hv_cmd_on <= 1'b0;
         end
      end
   end

   // status outputs
   reg [3:0] next_code;
   always @* begin
      if (!ilk_ok) begin
         next_code = `ERR_INTERLOCK;
      end else if (earth) begin
         next_code = `ERR_EARTH;
      end else if (vin_bad) begin
         next_code = `ERR_INPUT_V;
      end else if (hot) begin
         next_code = `ERR_TEMP;
      end else if (nvm_bad) begin
         next_code = `ERR_NVM;
      end else begin
         next_code = lat_code;
      end
   end
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         hv_output_o <= 1'b0;
         hv_lamp_o <= 1'b0;
         run_o <= 1'b0;
         error_o <= 1'b0;
         error_code_o <= `ERR_INTERLOCK;
         meter_range_o <= `METER_RESET;
         meter_mode_o <= 1'b0;
      end else begin
         hv_output_o <= ((st == ST_ON) || (st == ST_RUN)) && !err_any;
         hv_lamp_o <= (st == ST_RUN) && !err_any;
         run_o <= (st == ST_RUN) && !err_any;
         error_o <= err_any;
         error_code_o <= next_code;
         if (cmd_m && ex_noarg) begin
            meter_mode_o <= 1'b1;
         end else if (cmd_m && ex_arg == 8'h30) begin
            meter_mode_o <= 1'b0;
         end else if (cmd_m && ex_arg >= 8'h31 && ex_arg <= 8'h34) begin
            meter_range_o <= ex_arg[2:0];
         end
      end
   end

   // reply builder pushes into the fifo, stalled by its ready
   reg [7:0] resp_mem [0:5];
   reg [2:0] resp_len;
   reg [2:0] resp_idx;
   wire fifo_in_ready;
   wire pressure_range = (meter_range_o == 3'h2) || (meter_range_o == 3'h3);
   wire [7:0] mant_ch = (pressure_range && below_lim) ? 8'h30 : hex_ch(meter_value_i[15:12]);
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         resp_busy <= 1'b0;
         resp_len <= 3'h2;
         resp_idx <= 3'h0;
      end else if (go) begin
         resp_busy <= 1'b1;
         resp_idx <= 3'h0;
         resp_len <= 3'h2;
         resp_mem[0] <= CH_CR;
         resp_mem[1] <= CH_LF;
         case (ex_ch)
            CH_A, CH_B: begin
               resp_len <= 3'h3;
               resp_mem[0] <= {7'h18, (ex_ch == CH_A) ? below_p1 : below_p2};
               resp_mem[1] <= CH_CR;
               resp_mem[2] <= CH_LF;
            end
            CH_D: begin
               resp_len <= 3'h6;
               resp_mem[0] <= mant_ch;
               resp_mem[1] <= hex_ch(meter_value_i[11:8]);
               resp_mem[2] <= hex_ch(meter_value_i[7:4]);
               resp_mem[3] <= hex_ch(meter_value_i[3:0]);
               resp_mem[4] <= CH_CR;
               resp_mem[5] <= CH_LF;
            end
            CH_H, CH_M: begin
               if (ex_noarg) begin
                  resp_len <= 3'h3;
                  resp_mem[0] <= (ex_ch == CH_H) ? {7'h18, hv_output_o} : {5'h06, meter_range_o};
                  resp_mem[1] <= CH_CR;
                  resp_mem[2] <= CH_LF;
               end
            end
            default: resp_len <= 3'h2;
         endcase
      end else if (resp_busy && fifo_in_ready) begin
         resp_idx <= resp_idx + 3'h1;
         if (resp_idx + 3'h1 == resp_len) begin
            resp_busy <= 1'b0;
         end
      end
   end

   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   reg tx_busy;
   reply_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
      .clk_sys_i(clk_sys_i),
      .rst_i(rst_i),
      .in_valid_i(resp_busy),
      .in_ready_o(fifo_in_ready),
      .in_data_i(resp_mem[resp_idx]),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(!tx_busy),
      .out_data_o(fifo_out_data)
   );

   // transmitter: start bit, 8 data bits lsb first, stop bit
   reg [9:0] tx_sh;
   reg [3:0] tx_n;
   reg [16:0] tx_cnt;
   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         tx_busy <= 1'b0;
         tx_sh <= 10'h3FF;
         tx_n <= 4'h0;
         tx_cnt <= 17'h00000;
         uart_tx_o <= 1'b1;
      end else if (!tx_busy) begin
         uart_tx_o <= 1'b1;
         if (fifo_out_valid) begin
            tx_busy <= 1'b1;
            tx_sh <= {1'b1, fifo_out_data, 1'b0};
            tx_n <= 4'h0;
            tx_cnt <= 17'h00000;
         end
      end else if (tx_cnt != 17'h00000) begin
         tx_cnt <= tx_cnt - 17'h00001;
      end else if (tx_n == 4'hA) begin
         tx_busy <= 1'b0;
      end else begin
         uart_tx_o <= tx_sh[0];
         tx_sh <= {1'b1, tx_sh[9:1]};
         tx_n <= tx_n + 4'h1;
         tx_cnt <= bit_div - 17'h00001;
      end
   end
endmodule // ion_pump_hv_supervisor_serial_cmd
`default_nettype wire

// ===== bench/ion_pump_hv_supervisor_serial_cmd_sva.sv
// assertions on the supervisor top ports
// bound to the top module, single clock domain
`timescale 1ns/10ps
`default_nettype none
module sup_chk (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic interlock_closed_i,
   input wire logic earth_fault_i,
   input wire logic input_voltage_mismatch_i,
   input wire logic over_temp_i,
   input wire logic no_output_i,
   input wire logic hv_output_o,
   input wire logic hv_lamp_o,
   input wire logic run_o,
   input wire logic error_o,
   input wire logic [3:0] error_code_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   a_err_output_off: assert property (error_o [*3] |-> !hv_output_o && !run_o)
      else $error("output on during error");
   a_run_output_on: assert property (run_o |-> hv_output_o && hv_lamp_o)
      else $error("run without output or lamp");
   a_run_no_error: assert property ($rose(run_o) |-> !error_o)
      else $error("run entered with error");
   a_interlock_code: assert property (!interlock_closed_i [*6] |-> error_o && error_code_o == 4'h0)
      else $error("open loop code wrong");
   a_earth_code: assert property ((interlock_closed_i && earth_fault_i) [*6] |-> error_code_o == 4'h1)
      else $error("earth fault code wrong");
   a_supply_code: assert property ((interlock_closed_i && !earth_fault_i && input_voltage_mismatch_i) [*6]
      |-> error_code_o == 4'h5)
      else $error("input voltage code wrong");
   a_temp_code: assert property ((interlock_closed_i && !earth_fault_i && !input_voltage_mismatch_i
      && over_temp_i) [*6] |-> error_code_o == 4'h6)
      else $error("temperature code wrong");
   a_no_output_err: assert property (hv_output_o && no_output_i |-> ##[1:8] error_o)
      else $error("missing output not flagged");
endmodule // sup_chk
bind ion_pump_hv_supervisor_serial_cmd sup_chk u_chk (.clk_sys_i, .rst_i, .interlock_closed_i,
   .earth_fault_i, .input_voltage_mismatch_i, .over_temp_i, .no_output_i, .hv_output_o, .hv_lamp_o,
   .run_o, .error_o, .error_code_o);
`default_nettype wire

// ===== bench/host_uart_model.sv
// host end of the serial link: sends command bytes, collects reply bytes
// assumes bit period div_i in clock cycles, as set in the device
`timescale 1ns/10ps
`default_nettype none
module host_uart_model (
   input wire logic clk_sys_i,
   input wire logic [16:0] div_i,
   input wire logic dev_tx_i,
   output logic host_tx_o = 1'b1
);
   logic [7:0] rx_q[$];
   // start bit, eight data bits lsb first, one stop bit, no parity
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_tx_o = f[i];
         repeat (div_i) @(negedge clk_sys_i);
      end
   endtask
   always begin : rx_proc
      logic [7:0] b;
      @(negedge dev_tx_i);
      repeat (div_i / 2) @(posedge clk_sys_i);
      for (int i = 0; i < 8; i++) begin
         repeat (div_i) @(posedge clk_sys_i);
         b = {dev_tx_i, b[7:1]};
      end
      repeat (div_i) @(posedge clk_sys_i);
      if (dev_tx_i)
         rx_q.push_back(b);
   end
endmodule // host_uart_model
`default_nettype wire

// ===== bench/test_ion_pump_hv_supervisor_serial_cmd.sv
// bench for the supervisor: queries, meter, hv sequence, error codes
// assumes the host model on the serial pins, shortened second and bit periods
`timescale 1ns/10ps
`default_nettype none
`include "ion_pump_hv_supervisor_regs.vh"
module test_ion_pump_hv_supervisor_serial_cmd;
   localparam int SEC = 100;
   logic clk_sys_i = 1'b0, rst_i = 1'b1, uart_rx_i, uart_tx_o, remote_mode_i = 1'b0, hv_request_i = 1'b0;
   logic power_key_i = 1'b0, current_high_i = 1'b0, voltage_low_i = 1'b0, no_output_i = 1'b0;
   logic pressure_below_p1_i = 1'b0, pressure_below_p2_i = 1'b0, below_measure_limit_i = 1'b0;
   logic hv_output_o, hv_lamp_o, run_o, error_o, meter_mode_o;
   logic [1:0] baud_sel_i = 2'h0;
   logic [16:0] div = 17'h00010;
   logic [4:0] lv = 5'h00;
   logic [7:0] startup_timeout_min_i = 8'h01;
   logic [15:0] meter_value_i = 16'h9234;
   logic [3:0] error_code_o;
   logic [2:0] meter_range_o;
   logic [3:0] codes [5] = '{`ERR_INTERLOCK, `ERR_EARTH, `ERR_INPUT_V, `ERR_TEMP, `ERR_NVM};
   wire interlock_closed_i = !lv[0];
   wire earth_fault_i = lv[1];
   wire input_voltage_mismatch_i = lv[2];
   wire over_temp_i = lv[3];
   wire nvm_checksum_bad_i = lv[4];
   int n_errors = 0, n_compared = 0, cyc = 0;
   always #2.5 clk_sys_i = ~clk_sys_i;
   host_uart_model u_host (.clk_sys_i, .div_i(div), .dev_tx_i(uart_tx_o), .host_tx_o(uart_rx_i));
   ion_pump_hv_supervisor_serial_cmd #(.SEC_CYCLES(28'h0000064), .DIV_FAST(17'h00010),
      .DIV_MID(17'h00020), .DIV_SLOW(17'h00040)) u_dut (.clk_sys_i, .rst_i, .uart_rx_i, .uart_tx_o,
      .baud_sel_i, .remote_mode_i, .hv_request_i, .power_key_i, .interlock_closed_i, .earth_fault_i,
      .current_high_i, .voltage_low_i, .no_output_i, .input_voltage_mismatch_i, .over_temp_i,
      .nvm_checksum_bad_i, .pressure_below_p1_i, .pressure_below_p2_i, .below_measure_limit_i,
      .startup_timeout_min_i, .meter_value_i, .hv_output_o, .hv_lamp_o, .run_o, .error_o,
      .error_code_o, .meter_range_o, .meter_mode_o);
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic chk(input string w, input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", w, e, g);
      end
   endtask
   task automatic cmd(input string c, input string e);
      string g;
      logic [7:0] b;
      g = "";
      for (int i = 0; i < c.len(); i++)
         u_host.send_byte(c[i]);
      u_host.send_byte(8'h0D);
      for (int i = 0; i < 6000 && u_host.rx_q.size() < e.len() + 2; i++)
         tick(1);
      while (u_host.rx_q.size() > 0) begin
         b = u_host.rx_q.pop_front();
         // control bytes shown as letters: CR as M, LF as J
         g = $sformatf("%s%c", g, b < 8'h20 ? b + 8'h40 : b);
      end
      n_compared++;
      if (g != {e, "MJ"}) begin
         n_errors++;
         $display("MISMATCH reply to %s exp %sMJ got %s", c, e, g);
      end
   endtask
   task automatic t_query();
      for (int k = 0; k < 3; k++) begin
         baud_sel_i = k[1:0];
         div = 17'h00010 << k;
         pressure_below_p1_i = k[0];
         pressure_below_p2_i = !k[0];
         cmd("A", $sformatf("%0d", pressure_below_p1_i));
         cmd("B", $sformatf("%0d", pressure_below_p2_i));
      end
      baud_sel_i = 2'h0;
      div = 17'h00010;
   endtask
   task automatic t_meter();
      below_measure_limit_i = 1'b1;
      cmd("M", "1");
      chk("meter mode", 1, meter_mode_o);
      for (int r = 1; r < 5; r++) begin
         cmd($sformatf("M%0d", r), "");
         chk("meter range", r, meter_range_o);
         cmd("D", (r == 2 || r == 3) ? "0234" : "9234");
      end
      cmd("M", "4");
      cmd("M0", "");
      chk("meter mode", 0, meter_mode_o);
   endtask
   task automatic t_levels();
      for (int i = 0; i < 5; i++) begin
         lv = 5'h01 << i;
         tick(8);
         chk("level code", codes[i], error_code_o);
         lv = 5'h00;
         tick(8);
         chk("level gone", 0, error_o);
      end
      cmd("Q1E-05", "");
      chk("serial code", `ERR_SERIAL, error_code_o);
      cmd("C", "");
      chk("cleared", 0, error_o);
   endtask
   task automatic t_timeout();
      int t;
      remote_mode_i = 1'b1;
      current_high_i = 1'b1;
      hv_request_i = 1'b1;
      for (t = 0; t < 400 && !hv_output_o; t++)
         tick(1);
      for (t = 0; hv_output_o; t++)
         tick(1);
      chk("on cycles", SEC, t);
      for (t = 0; !hv_output_o; t++)
         tick(1);
      chk("off cycles", 2 * SEC, t);
      for (t = 3 * SEC; !error_o && t < 70 * SEC; t++)
         tick(1);
      chk("timeout time", 1, t >= 60 * SEC - 4 && t <= 60 * SEC + 4);
      chk("timeout code", `ERR_TIMEOUT, error_code_o);
      tick(3);
      chk("off in error", 0, {hv_output_o, run_o});
      hv_request_i = 1'b0;
      tick(8);
      chk("request clears", 0, error_o);
      current_high_i = 1'b0;
      remote_mode_i = 1'b0;
   endtask
   task automatic t_run();
      int t;
      cmd("H1", "");
      chk("run lamp", 3, {run_o, hv_lamp_o});
      cmd("H", "1");
      voltage_low_i = 1'b1;
      for (t = 0; !error_o && t < 4 * SEC; t++)
         tick(1);
      chk("low time", 1, t >= 2 * SEC && t <= 2 * SEC + 8);
      chk("run code", `ERR_RUN, error_code_o);
      voltage_low_i = 1'b0;
      power_key_i = 1'b1;
      tick(8);
      power_key_i = 1'b0;
      chk("key clears", 0, error_o);
      cmd("H", "0");
      cmd("H1", "");
      no_output_i = 1'b1;
      tick(8);
      chk("no output code", `ERR_HV_OUTPUT, error_code_o);
      no_output_i = 1'b0;
      cmd("C", "");
      chk("off after clear", 0, {hv_output_o, error_o});
   endtask
   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 90000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      tick(5);
      rst_i = 1'b0;
      tick(2);
      chk("error after reset", 0, error_o);
      tick(2);
      chk("tx idle", 1, uart_tx_o);
      chk("meter range", `METER_RESET, meter_range_o);
      chk("outputs", 0, {hv_output_o, run_o, error_o, meter_mode_o});
      t_query();
      t_meter();
      t_levels();
      t_timeout();
      t_run();
      stop_test();
   end
endmodule // test_ion_pump_hv_supervisor_serial_cmd
`default_nettype wire
